/* core/isid_top.sv */
// identity register and upper interrupt status register block
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - otp write done sets bit 28
// - tx lpi entry pulse sets bit 26
// - tx lpi exit pulse sets bit 25
// - rx lpi entry pulse sets bit 24
// - low power bits zero when disabled
// - 8 ms watchdog timeout sets bit 23
// - watchdog expiry releases mac reset
// - write into full fifo sets 22
// - drop receive data during overflow
// - transmit error level sets bit 21
// - read only model and revision register
// - revision value taken from silicon strap
module isid_top #(
  parameter int          WD_CYCLES  = isid_pkg::ISID_WD_CYCLES,
  // model code value is arbitrary
  parameter logic [15:0] MODEL_CODE = 16'h5a3c
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // register port
  input  wire logic [11:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // event sources
  input  wire logic        otp_wr_done,
  input  wire logic        tx_low_power_entry_event,
  input  wire logic        tx_low_power_exit_event,
  input  wire logic        rx_low_power_entry_event,
  input  wire logic        tx_error_level,
  // receive fifo write path
  input  wire logic        rx_wr_req,
  input  wire logic        rx_fifo_full,
  output logic             rx_fifo_wr,
  // mac reset
  input  wire logic        phy_clks_ok,
  output logic             mac_rst_n,
  // silicon revision strap
  input  wire logic [15:0] rev_strap,
  // energy efficient enable to the mac
  output logic             energy_efficient_enable,
  // interrupt
  output logic             irq
);

  isid_pkg::isid_regs_t q;
  isid_pkg::isid_regs_t n;
  isid_pkg::isid_src_t  src;

  logic        wd_busy;
  logic        wd_timeout;
  logic [31:0] events;
  logic [31:0] w1c;
  logic [31:0] sts_keep;
  logic [31:0] sts_raw;

  assign src.otp_wr_done  = otp_wr_done;
  assign src.tx_lpi_entry = tx_low_power_entry_event;
  assign src.tx_lpi_exit  = tx_low_power_exit_event;
  assign src.rx_lpi_entry = rx_low_power_entry_event;
  assign src.rx_wr_req    = rx_wr_req;
  assign src.rx_fifo_full = rx_fifo_full;
  assign src.tx_error     = tx_error_level;

  // mac reset watchdog
  isid_mac_rst_wd #(
    .WD_CYCLES   (WD_CYCLES)
  ) u_wd (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n),
    .start       (q.rst_req),
    .phy_clks_ok (phy_clks_ok),
    .mac_rst_n   (mac_rst_n),
    .busy        (wd_busy),
    .timeout     (wd_timeout)
  );

  // event vector
  always_comb
  begin
    events = 32'h0000_0000;
    events[isid_pkg::ISID_BIT_OTP_DONE]     = src.otp_wr_done;
    events[isid_pkg::ISID_BIT_TX_LPI_ENTRY] = src.tx_lpi_entry;
    events[isid_pkg::ISID_BIT_TX_LPI_EXIT]  = src.tx_lpi_exit;
    events[isid_pkg::ISID_BIT_RX_LPI_ENTRY] = src.rx_lpi_entry;
    events[isid_pkg::ISID_BIT_MAC_RST_TO]   = wd_timeout;
    events[isid_pkg::ISID_BIT_RX_OVERFLOW]  = src.rx_wr_req & src.rx_fifo_full;
    events[isid_pkg::ISID_BIT_TX_ERROR]     = src.tx_error;
  end

  // write one to clear pattern
  assign w1c = (reg_wr && reg_addr == isid_pkg::ISID_OFS_STATUS)
             ? (reg_wdata & isid_pkg::ISID_STS_IMPL) : 32'h0000_0000;

  // per bit status update
  for (genvar b = 0; b < 32; b++)
  begin : g_sts
    if (isid_pkg::ISID_STS_IMPL[b])
    begin : g_impl
      assign sts_keep[b] = q.status[b] & ~w1c[b];
      assign sts_raw[b]  = sts_keep[b] | events[b];
    end
    else
    begin : g_resvd
      assign sts_keep[b] = 1'b0;
      assign sts_raw[b]  = 1'b0;
    end
  end

  // next state
  always_comb
  begin
    n         = q;
    n.rst_req = 1'b0;
    n.rdata   = isid_pkg::ISID_RST_RDATA;

    n.rev_cap = 1'b1;
    if (!q.rev_cap)
    begin
      n.rev = rev_strap;
    end

    if (reg_wr)
    begin
      case (reg_addr)
        isid_pkg::ISID_OFS_MASK:
        begin
          n.mask = reg_wdata & isid_pkg::ISID_STS_IMPL;
        end
        isid_pkg::ISID_OFS_CTRL:
        begin
          n.ee_en   = reg_wdata[isid_pkg::ISID_CTRL_EE_EN];
          n.rst_req = reg_wdata[isid_pkg::ISID_CTRL_MAC_RST] & ~wd_busy;
        end
        default:
        begin
          n.ee_en = q.ee_en;
        end
      endcase
    end

    n.status = sts_raw;

    if (!n.ee_en)
    begin
      n.status = n.status & ~isid_pkg::ISID_STS_EEE;
    end

    // interrupt level
    n.irq = |(n.status & n.mask);

    n.rx_wr = src.rx_wr_req & ~src.rx_fifo_full
            & ~q.status[isid_pkg::ISID_BIT_RX_OVERFLOW];

    if (reg_rd)
    begin
      case (reg_addr)
        isid_pkg::ISID_OFS_IDENT:
        begin
          n.rdata = {MODEL_CODE, q.rev};
        end
        isid_pkg::ISID_OFS_STATUS:
        begin
          n.rdata = q.status;
        end
        isid_pkg::ISID_OFS_MASK:
        begin
          n.rdata = q.mask;
        end
        isid_pkg::ISID_OFS_CTRL:
        begin
          n.rdata                               = 32'h0000_0000;
          n.rdata[isid_pkg::ISID_CTRL_EE_EN]    = q.ee_en;
          n.rdata[isid_pkg::ISID_CTRL_RST_BUSY] = wd_busy;
        end
        default:
        begin
          n.rdata = isid_pkg::ISID_RST_RDATA;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q.status  <= isid_pkg::ISID_RST_STATUS;
      q.mask    <= isid_pkg::ISID_RST_MASK;
      q.ee_en   <= 1'b0;
      q.rst_req <= 1'b0;
      q.rev     <= isid_pkg::ISID_RST_REV;
      q.rev_cap <= 1'b0;
      q.rdata   <= isid_pkg::ISID_RST_RDATA;
      q.irq     <= 1'b0;
      q.rx_wr   <= 1'b0;
    end
    else
    begin
      q <= n;
    end
  end

  assign reg_rdata               = q.rdata;
  assign irq                     = q.irq;
  assign rx_fifo_wr              = q.rx_wr;
  assign energy_efficient_enable = q.ee_en;

endmodule
`default_nettype wire

/* inc/isid_pkg.sv */
// constants and types for the interrupt status and identity block
package isid_pkg;

  // register bus
  localparam int          ISID_AW               = 12;
  localparam int          ISID_DW               = 32;

  // register offsets (byte addresses)
  localparam logic [11:0] ISID_OFS_IDENT        = 12'h000;
  localparam logic [11:0] ISID_OFS_STATUS       = 12'h00c;
  localparam logic [11:0] ISID_OFS_MASK         = 12'h0f8;
  localparam logic [11:0] ISID_OFS_CTRL         = 12'h0fc;

  // status bit positions
  localparam int          ISID_BIT_OTP_DONE     = 28;
  localparam int          ISID_BIT_TX_LPI_ENTRY = 26;
  localparam int          ISID_BIT_TX_LPI_EXIT  = 25;
  localparam int          ISID_BIT_RX_LPI_ENTRY = 24;
  localparam int          ISID_BIT_MAC_RST_TO   = 23;
  localparam int          ISID_BIT_RX_OVERFLOW  = 22;
  localparam int          ISID_BIT_TX_ERROR     = 21;

  // implemented status bits and the low power group
  localparam logic [31:0] ISID_STS_IMPL         = 32'h17e0_0000;
  localparam logic [31:0] ISID_STS_EEE          = 32'h0700_0000;

  // control register fields
  localparam int          ISID_CTRL_MAC_RST     = 0;
  localparam int          ISID_CTRL_EE_EN       = 1;
  localparam int          ISID_CTRL_RST_BUSY    = 2;

  // identity fields
  localparam int          ISID_ID_MODEL_LSB     = 16;
  localparam int          ISID_CHIP_IDENTITY_REVISION_W         = 16;

  // reset values
  localparam logic [31:0] ISID_RST_STATUS       = 32'h0000_0000;
  localparam logic [31:0] ISID_RST_MASK         = 32'h0000_0000;
  localparam logic [15:0] ISID_RST_REV          = 16'h0000;
  localparam logic [31:0] ISID_RST_RDATA        = 32'h0000_0000;

  // mac reset watchdog timing
  localparam int          ISID_CLK_PERIOD_PS    = 8000;
  localparam longint      ISID_WD_TIME_MS       = 8;
  localparam int          ISID_WD_CYCLES        =
    int'((ISID_WD_TIME_MS * 64'd1000000000) / ISID_CLK_PERIOD_PS);
  localparam int          ISID_WD_CW            = 20;
  localparam logic [19:0] ISID_WD_CNT_RST       = 20'h0_0000;

  // watchdog states
  typedef enum logic [1:0] {
    ISID_WD_IDLE = 2'b01,
    ISID_WD_WAIT = 2'b10
  } isid_wd_state_t;

  // watchdog state record
  typedef struct packed {
    isid_wd_state_t        st;
    logic [19:0]           cnt;
    logic                  mac_rst_n;
    logic                  timeout;
  } isid_wd_t;

  // main block state record
  typedef struct packed {
    logic [31:0]           status;
    logic [31:0]           mask;
    logic                  ee_en;
    logic                  rst_req;
    logic [15:0]           rev;
    logic                  rev_cap;
    logic [31:0]           rdata;
    logic                  irq;
    logic                  rx_wr;
  } isid_regs_t;

  // event sources
  typedef struct packed {
    logic                  otp_wr_done;
    logic                  tx_lpi_entry;
    logic                  tx_lpi_exit;
    logic                  rx_lpi_entry;
    logic                  rx_wr_req;
    logic                  rx_fifo_full;
    logic                  tx_error;
  } isid_src_t;

endpackage

/* core/isid_mac_rst_wd.sv */
// mac reset watchdog: holds mac reset until phy clocks or timeout
`timescale 1ns/1ps
`default_nettype none
module isid_mac_rst_wd #(
  parameter int WD_CYCLES = isid_pkg::ISID_WD_CYCLES
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // control
  input  wire logic start,
  input  wire logic phy_clks_ok,
  // status
  output logic      mac_rst_n,
  output logic      busy,
  output logic      timeout
);

  localparam logic [19:0] LAST = 20'(WD_CYCLES - 1);

  isid_pkg::isid_wd_t q;
  isid_pkg::isid_wd_t n;

  always_comb
  begin
    n         = q;
    n.timeout = 1'b0;
    case (q.st)
      isid_pkg::ISID_WD_IDLE:
      begin
        if (start)
        begin
          n.st        = isid_pkg::ISID_WD_WAIT;
          n.cnt       = isid_pkg::ISID_WD_CNT_RST;
          n.mac_rst_n = 1'b0;
        end
      end
      isid_pkg::ISID_WD_WAIT:
      begin
        n.cnt = q.cnt + 20'h0_0001;
        if (phy_clks_ok)
        begin
          n.st        = isid_pkg::ISID_WD_IDLE;
          n.mac_rst_n = 1'b1;
        end
        else if (q.cnt == LAST)
        begin
          n.st        = isid_pkg::ISID_WD_IDLE;
          n.mac_rst_n = 1'b1;
          n.timeout   = 1'b1;
        end
      end
      default:
      begin
        n.st        = isid_pkg::ISID_WD_IDLE;
        n.mac_rst_n = 1'b1;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q.st        <= isid_pkg::ISID_WD_IDLE;
      q.cnt       <= isid_pkg::ISID_WD_CNT_RST;
      q.mac_rst_n <= 1'b1;
      q.timeout   <= 1'b0;
    end
    else
    begin
      q <= n;
    end
  end

  assign mac_rst_n = q.mac_rst_n;
  assign busy      = (q.st == isid_pkg::ISID_WD_WAIT);
  assign timeout   = q.timeout;

endmodule
`default_nettype wire

/* verif/isid_assertions.sv */
// checker of the status and identity block ports
`timescale 1ns/1ps
`default_nettype none
module isid_chk #(
  parameter int          WD_CYCLES  = 20,
  parameter logic [15:0] MODEL_CODE = 16'h0000
) (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rst_n,
  // register port
  input wire logic [11:0] reg_addr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  // sources and outputs
  input wire logic        otp_wr_done,
  input wire logic        tx_low_power_entry_event,
  input wire logic        tx_error_level,
  input wire logic        rx_wr_req,
  input wire logic        rx_fifo_full,
  input wire logic        rx_fifo_wr,
  input wire logic        mac_rst_n,
  input wire logic        energy_efficient_enable
);
  logic [31:0] low_cnt_r;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  sequence rd_sts;
    reg_rd && reg_addr == 12'h00c;
  endsequence
  sequence ovf;
    rx_wr_req && rx_fifo_full;
  endsequence
  // cycles spent in mac reset
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
      low_cnt_r <= 32'h0000_0000;
    else
      low_cnt_r <= mac_rst_n ? 32'h0000_0000 : low_cnt_r + 32'h0000_0001;
  a_id_model: assert property (reg_rd && reg_addr == 12'h000 |=>
    reg_rdata[31:16] == MODEL_CODE) else $error("bad model code");
  a_sts_resvd: assert property (rd_sts |=>
    (reg_rdata & ~isid_pkg::ISID_STS_IMPL) == 32'h0000_0000) else $error("reserved bit set");
  a_ee_forced: assert property (!energy_efficient_enable ##0 rd_sts |=>
    reg_rdata[26:24] == 3'b000) else $error("low power bit set while off");
  a_tx_entry: assert property (tx_low_power_entry_event ##1
    energy_efficient_enable ##0 rd_sts |=> reg_rdata[26]) else $error("bit 26 lost");
  a_otp_done: assert property (otp_wr_done ##1 rd_sts |=> reg_rdata[28])
    else $error("bit 28 lost");
  a_tx_error: assert property (tx_error_level [*2] ##0 rd_sts |=> reg_rdata[21])
    else $error("bit 21 lost");
  a_ovf_set: assert property (ovf ##1 rd_sts |=> reg_rdata[22])
    else $error("bit 22 lost");
  a_ovf_drop: assert property (ovf |=> !rx_fifo_wr [*2])
    else $error("write during overflow");
  a_wd_bound: assert property (low_cnt_r <= 32'(WD_CYCLES + 2))
    else $error("mac reset held too long");
endmodule
bind isid_top isid_chk #(.WD_CYCLES(WD_CYCLES), .MODEL_CODE(MODEL_CODE)) u_chk (
  .sys_clk, .rst_n, .reg_addr, .reg_rd, .reg_rdata, .otp_wr_done,
  .tx_low_power_entry_event, .tx_error_level, .rx_wr_req, .rx_fifo_full,
  .rx_fifo_wr, .mac_rst_n, .energy_efficient_enable);
`default_nettype wire

/* verif/tb_top.sv */
// self-checking bench of the status and identity block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int          WD  = 20;
  localparam logic [15:0] MC  = 16'h1b2d;
  localparam logic [11:0] STS = 12'h00c;
  localparam logic [11:0] MSK = 12'h0f8;
  localparam logic [11:0] CTL = 12'h0fc;
  localparam logic [31:0] ONE = 32'hffff_ffff;
  logic        sys_clk = 1'b0;
  logic        rst_n   = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic        reg_wr  = 1'b0;
  logic        reg_rd  = 1'b0;
  logic [7:0]  ev      = 8'h00;
  logic [7:0]  lvl     = 8'h00;
  logic        wr_req  = 1'b0;
  logic        phy_ok  = 1'b0;
  logic [15:0] strap   = 16'h0000;
  logic [7:0]  tbl [6] = '{8'h80, 8'h20, 8'h10, 8'h08, 8'h02, 8'h01};
  logic [31:0] reg_rdata;
  logic [31:0] d;
  logic        rx_fifo_wr;
  logic        mac_rst_n;
  logic        ee;
  logic        irq;
  int          fail_count = 0;
  int          cmp_count = 0;
  int          n;
  isid_top #(.WD_CYCLES(WD), .MODEL_CODE(MC)) uut (
    .sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .otp_wr_done(ev[7]), .tx_low_power_entry_event(ev[5]),
    .tx_low_power_exit_event(ev[4]), .rx_low_power_entry_event(ev[3]),
    .tx_error_level(ev[0]), .rx_wr_req(ev[1] | wr_req), .rx_fifo_full(ev[1]),
    .rx_fifo_wr, .phy_clks_ok(phy_ok), .mac_rst_n, .rev_strap(strap),
    .energy_efficient_enable(ee), .irq);
  always #4 sys_clk = ~sys_clk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string w);
    cmp_count++;
    if (seen !== exp)
    begin
      $display("Error %s expected %h seen %h", w, exp, seen);
      fail_count++;
    end
  endtask
  function automatic logic [31:0] exp_sts(input logic [7:0] e, input logic en);
    exp_sts = (32'(e & 8'hbb) << 21) & (en ? ONE : ~isid_pkg::ISID_STS_EEE);
  endfunction
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    ev <= lvl;
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string w);
    @(posedge sys_clk);
    ev <= lvl;
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e, w);
  endtask
  task automatic end_of_test;
    if (fail_count == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    fail_count++;
    end_of_test();
  end
  initial
  begin
    void'($urandom(32'h631e_f5e1));
    strap <= 16'($urandom());
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    wr(12'h000, ONE);
    rd(12'h000, {MC, strap}, "id");
    rd(STS, 0, "status reset");
    rd(12'h010, 0, "unmapped");
    d = $urandom();
    wr(MSK, d);
    rd(MSK, d & isid_pkg::ISID_STS_IMPL, "mask");
    wr(MSK, ONE);
    wr(CTL, 32'h0000_0002);
    #1 chk(ee, 1, "enable on");
    for (int i = 0; i < 10; i++)
    begin
      d = (i < 6) ? 32'(tbl[i]) : ($urandom() & 32'h0000_00bb);
      @(posedge sys_clk);
      ev <= d[7:0];
      rd(STS, exp_sts(d[7:0], 1'b1), "status set");
      chk(irq, d != 0, "irq set");
      wr(STS, ONE);
      rd(STS, 0, "status clear");
      chk(irq, 0, "irq clear");
    end
    lvl = 8'h81;
    wr(STS, ONE);
    wr(STS, ONE);
    rd(STS, 32'h1020_0000, "level kept");
    lvl = 8'h00;
    wr(STS, ONE);
    rd(STS, 0, "level gone");
    wr(MSK, 0);
    @(posedge sys_clk);
    ev <= 8'h08;
    rd(STS, 32'h0100_0000, "masked status");
    chk(irq, 0, "masked irq");
    wr(MSK, ONE);
    @(posedge sys_clk);
    #1 chk(irq, 1, "unmasked irq");
    wr(CTL, 0);
    #1 chk(ee, 0, "enable off");
    @(posedge sys_clk);
    ev <= 8'h38;
    rd(STS, exp_sts(8'h38, 1'b0), "forced low");
    @(posedge sys_clk);
    wr_req <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 chk(rx_fifo_wr, 1, "fifo write");
    @(posedge sys_clk);
    ev <= 8'h02;
    rd(STS, 32'h0040_0000, "overflow");
    chk(rx_fifo_wr, 0, "fifo drop");
    wr(STS, ONE);
    @(posedge sys_clk);
    #1 chk(rx_fifo_wr, 1, "fifo resumed");
    wr(CTL, 32'h0000_0001);
    n = 0;
    while (mac_rst_n !== 1'b0 && n < 8)
      @(posedge sys_clk) #1 n++;
    n = 0;
    while (mac_rst_n === 1'b0 && n < 99)
      @(posedge sys_clk) #1 n++;
    chk(n, WD, "reset time");
    rd(STS, 32'h0080_0000, "timeout");
    @(posedge sys_clk);
    phy_ok <= 1'b1;
    wr(STS, ONE);
    wr(CTL, 32'h0000_0001);
    n = 0;
    repeat (6) @(posedge sys_clk) #1 n += 32'(!mac_rst_n);
    chk(n inside {[1:2]}, 1, "early release");
    rd(STS, 0, "no timeout");
    // mid-run reset reloads revision and clears status
    @(posedge sys_clk);
    ev <= 8'h01;
    @(posedge sys_clk);
    ev <= 8'h00;
    @(posedge sys_clk);
    strap <= 16'($urandom());
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(12'h000, {MC, strap}, "id after reset");
    rd(STS, 0, "status after reset");
    end_of_test();
  end
endmodule
`default_nettype wire
